/* File: src/safety_diag_pkg.sv */
// Purpose: Shared constants, bit maps and carriers of the serial diagnostic block
// Assumes: 10 MHz system clock
// Notes:   Byte layouts are fixed by the chain's data images
package safety_diag_pkg;

   // Clock and timing
   localparam longint CLK_HZ          = 10_000_000;
   localparam longint WARN_MINUTES    = 30;
   localparam longint WARN_CYCLES     = WARN_MINUTES * 60 * CLK_HZ;
   localparam longint COMM_TIMEOUT_MS = 100;
   localparam longint COMM_CYCLES     = COMM_TIMEOUT_MS * CLK_HZ / 1000;
   localparam longint SD_BAUD         = 100_000;
   localparam int     BIT_CYCLES      = int'(CLK_HZ / SD_BAUD);
   localparam int     GAP_BITS        = 20;
   localparam int     GAP_CYCLES      = GAP_BITS * BIT_CYCLES;
   localparam int     WARN_CNT_W      = 36;
   localparam int     COMM_CNT_W      = 24;
   localparam int     MAX_UNITS       = 31;

   // Request byte field
   localparam int     REQ_ERROR_RESET = 7;

   // Reset values of the data images and last append index
   localparam logic [7:0] REQ_RESET   = 8'h00;
   localparam logic [7:0] BYTE_RESET  = 8'h00;
   localparam logic [1:0] APPEND_LAST = 2'h2;

   // Response byte
   typedef struct packed {
      logic error_off;
      logic error_warning;
      logic guard_detected;
      logic inputs_active;
      logic unused3;
      logic unused2;
      logic actuator_detected;
      logic outputs_enabled;
   } response_type;

   // Warning diagnostic byte
   typedef struct packed {
      logic unused7;
      logic comm_fault;
      logic internal_fault;
      logic unused4;
      logic over_temp;
      logic cross_short;
      logic second_output_fault;
      logic first_output_fault;
   } warning_diag_type;

   // Error diagnostic byte
   typedef struct packed {
      logic unused7;
      logic unused6;
      logic internal_fault;
      logic actuator_fault;
      logic over_temp;
      logic cross_short;
      logic second_output_fault;
      logic first_output_fault;
   } error_diag_type;

   // Synchronised fault sense lines
   typedef struct packed {
      logic internal_fault;
      logic actuator_combo;
      logic actuator_fault;
      logic over_temp;
      logic cross_short;
      logic second_output_fault;
      logic first_output_fault;
   } fault_sense_type;

endpackage

/* File: src/safety_switch_serial_diagnostics.sv */
// Purpose: Serial diagnostic chain node and fault handling of a safety interlock switch
// Assumes: All sense pins and the serial input are asynchronous to sys_clk
// Notes:   Power cycling is modelled by reset_n; it alone ends a lockout
// Summary of operation
// RQ1: A chain holds at most thirty-one switches on one diagnostic line.
// RQ2: Traffic enters on the serial input and leaves on the serial output.
// RQ3: Response and diagnostic bytes are sent every frame without being asked.
// RQ4: The gateway supplies one request byte per switch in the chain.
// RQ5: A gateway communication fault leaves the safety outputs as they are.
// RQ6: Error clears once cause is gone and request bit 7 falls or guard opens.
// RQ7: Output-located error bits clear only at the next enabling of the outputs; a new error set also reloads them from the sense lines.
// RQ8: Double output fault or cross short latches a lockout acknowledge cannot clear.
// RQ9: Only power removal and reapplication releases the lockout.
// RQ10: Warning keeps outputs on, then disables them after thirty minutes.
// RQ11: A warning clears itself as soon as its cause disappears.
// RQ12: Diagnostic bytes are offered whenever the response flags error or warning.
// RQ13: Every request, response and diagnostic bit is active high.
// RQ14: Response: bit0 enabled, bit1 actuator, bit4 inputs, bit5 guard, bit6 warn, bit7 error.
// RQ15: Warning byte: outputs, cross short, temperature, internal, communication; bit4 unused.
// RQ16: Error byte: outputs, cross short, temperature, actuator, internal.
// RQ17: The gateway attaches to the serial input of the first switch.
// RQ18: Actuator and actuator combination faults disable the outputs at once.
// RQ19: Units pair with request and response bytes by chain position.
`timescale 1ns/1ps
`default_nettype none

module safety_switch_serial_diagnostics
   import safety_diag_pkg::*;
#(
   parameter logic [WARN_CNT_W-1:0] WARN_LIMIT = WARN_CNT_W'(WARN_CYCLES),
   parameter logic [COMM_CNT_W-1:0] COMM_LIMIT = COMM_CNT_W'(COMM_CYCLES)
)
(
   input  wire logic sys_clk,
   input  wire logic reset_n,
   input  wire logic serial_diag_in,
   input  wire logic first_safety_input,
   input  wire logic second_safety_input,
   input  wire logic actuator_present,
   input  wire logic guard_closed,
   input  wire logic first_output_fault,
   input  wire logic second_output_fault,
   input  wire logic cross_short,
   input  wire logic over_temp,
   input  wire logic actuator_fault,
   input  wire logic actuator_combo,
   input  wire logic internal_fault,
   output logic      serial_diag_out,
   output logic      first_safety_output,
   output logic      second_safety_output
);

   localparam int NPIN = 12;
   localparam logic [8:0] BIT_LAST = 9'(BIT_CYCLES - 1);
   localparam logic [8:0] BIT_HALF = 9'(BIT_CYCLES / 2 - 1);
   localparam logic [11:0] GAP_LAST = 12'(GAP_CYCLES - 1);

   typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10,
                             RX_STOP = 2'b11} rx_state_type;
   typedef enum logic [1:0] {CH_IDLE = 2'b00, CH_FRAME = 2'b01,
                             CH_APPEND = 2'b10} chain_state_type;

   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] sync1;
   logic [NPIN-1:0] sync2;
   logic [NPIN-1:0] sync3;
   logic [NPIN-1:0] pin_clean;
   fault_sense_type faults;
   logic rx_line;
   logic in1;
   logic in2;
   logic actuator;
   logic guard;
   logic guard_prev;

   rx_state_type rx_state;
   logic [8:0]   rx_timer;
   logic [2:0]   rx_idx;
   logic [7:0]   rx_shift;
   logic         rx_done;
   logic [7:0]   rx_byte;

   logic [9:0]   tx_shift;
   logic [3:0]   tx_left;
   logic [8:0]   tx_timer;
   logic         tx_busy;
   logic         tx_go;
   logic [7:0]   tx_byte;
   logic         pend_valid;
   logic [7:0]   pend_byte;

   chain_state_type chain_state;
   logic [11:0]  gap_cnt;
   logic [1:0]   append_idx;
   logic [7:0]   command_request_byte;
   logic         ack_request;
   logic [COMM_CNT_W-1:0] comm_cnt;
   logic         comm_fault;

   response_type     state_response_byte;
   warning_diag_type warning_diag_byte;
   error_diag_type   error_diag_byte;
   logic [WARN_CNT_W-1:0] warn_cnt;
   logic         warn_src;
   logic         imm_src;
   logic         cause_gone;
   logic         error_set;
   logic         error_clear;
   logic         error_off;
   logic         lockout;
   logic         env_ok;
   logic         out_en;

   // Every asynchronous pin passes the same three-stage filter
   assign pin_raw = {serial_diag_in, first_safety_input, second_safety_input, actuator_present,
                     guard_closed, internal_fault, actuator_combo, actuator_fault, over_temp,
                     cross_short, second_output_fault, first_output_fault};

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++)
      begin : g_sync
         // Only stage two reads stage one; serial line resets to its idle high
         always_ff @(posedge sys_clk or negedge reset_n)
         begin
            if (!reset_n)
            begin
               sync1[gi]     <= (gi == NPIN - 1);
               sync2[gi]     <= (gi == NPIN - 1);
               sync3[gi]     <= (gi == NPIN - 1);
               pin_clean[gi] <= (gi == NPIN - 1);
            end
            else
            begin
               sync1[gi] <= pin_raw[gi];
               sync2[gi] <= sync1[gi];
               sync3[gi] <= sync2[gi];
               if (sync2[gi] == sync3[gi])
                  pin_clean[gi] <= sync3[gi];
            end
         end
      end
   endgenerate

   assign rx_line  = pin_clean[11];                // [RQ2]
   assign in1      = pin_clean[10];
   assign in2      = pin_clean[9];
   assign actuator = pin_clean[8];
   assign guard    = pin_clean[7];
   assign faults   = fault_sense_type'(pin_clean[6:0]);

   // Serial receiver, start bit sampled mid-bit, LSB first
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rx_state <= RX_IDLE;
         rx_timer <= 9'h000;
         rx_idx   <= 3'h0;
         rx_shift <= BYTE_RESET;
         rx_done  <= 1'b0;
         rx_byte  <= BYTE_RESET;
      end
      else
      begin
         rx_done <= 1'b0;
         if (rx_state != RX_IDLE && rx_timer != 9'h000)
            rx_timer <= rx_timer - 9'h001;
         else
            case (rx_state)
               RX_IDLE:
                  if (!rx_line)
                  begin
                     rx_state <= RX_START;
                     rx_timer <= BIT_HALF;
                  end
               RX_START:
               begin
                  // A glitch shorter than half a bit is dropped here
                  rx_state <= rx_line ? RX_IDLE : RX_DATA;
                  rx_timer <= BIT_LAST;
                  rx_idx   <= 3'h0;
               end
               RX_DATA:
               begin
                  rx_shift <= {rx_line, rx_shift[7:1]};
                  rx_timer <= BIT_LAST;
                  rx_idx   <= rx_idx + 3'h1;
                  if (rx_idx == 3'h7)
                     rx_state <= RX_STOP;
               end
               RX_STOP:
               begin
                  rx_state <= RX_IDLE;
                  rx_done  <= rx_line;                // Framing error discards the byte
                  rx_byte  <= rx_shift;
               end
               default:
                  rx_state <= RX_IDLE;
            endcase
      end
   end

   // Serial transmitter; line idles high
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tx_shift        <= 10'h3ff;
         tx_left         <= 4'h0;
         tx_timer        <= 9'h000;
         serial_diag_out <= 1'b1;
      end
      else if (tx_go && !tx_busy)
      begin
         tx_shift        <= {1'b1, tx_byte, 1'b0};
         tx_left         <= 4'ha;
         tx_timer        <= 9'h000;
         serial_diag_out <= 1'b1;
      end
      else if (tx_left != 4'h0)
      begin
         if (tx_timer == 9'h000)
         begin
            serial_diag_out <= tx_shift[0];          // [RQ2]
            tx_shift        <= {1'b1, tx_shift[9:1]};
            tx_left         <= tx_left - 4'h1;
            tx_timer        <= BIT_LAST;
         end
         else
            tx_timer <= tx_timer - 9'h001;
      end
      else if (tx_timer != 9'h000)
         tx_timer <= tx_timer - 9'h001;             // Let the stop bit run its full time
   end

   assign tx_busy = (tx_left != 4'h0) || (tx_timer != 9'h000);

   // Forwarded traffic first, then the images
   always_comb
   begin
      tx_go   = 1'b0;
      tx_byte = pend_byte;
      if (pend_valid)
         tx_go = 1'b1;
      else if (chain_state == CH_APPEND)
      begin
         tx_go = 1'b1;
         case (append_idx)
            2'h0:    tx_byte = state_response_byte;
            2'h1:    tx_byte = warning_diag_byte;
            default: tx_byte = error_diag_byte;
         endcase
      end
   end

   // Chain position: first byte of a frame is ours, the rest pass on [RQ1]
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         chain_state          <= CH_IDLE;
         gap_cnt              <= 12'h000;
         append_idx           <= 2'h0;
         pend_valid           <= 1'b0;
         pend_byte            <= BYTE_RESET;
         command_request_byte <= REQ_RESET;
         ack_request          <= 1'b0;
      end
      else
      begin
         ack_request <= 1'b0;
         if (pend_valid && !tx_busy)
            pend_valid <= 1'b0;
         gap_cnt <= (rx_state != RX_IDLE) ? 12'h000 :
                    (gap_cnt == GAP_LAST) ? gap_cnt : gap_cnt + 12'h001;
         case (chain_state)
            CH_IDLE:
               if (rx_done)
               begin
                  // Own request byte is stripped off the head [RQ4] [RQ19]
                  command_request_byte <= rx_byte;
                  ack_request <= command_request_byte[REQ_ERROR_RESET] &
                                 !rx_byte[REQ_ERROR_RESET];      // [RQ6]
                  chain_state <= CH_FRAME;
               end
            CH_FRAME:
               if (rx_done)
               begin
                  pend_valid <= 1'b1;                         // [RQ2]
                  pend_byte  <= rx_byte;
               end
               else if (gap_cnt == GAP_LAST && !pend_valid && !tx_busy)
               begin
                  chain_state <= CH_APPEND;                   // [RQ3]
                  append_idx  <= 2'h0;
               end
            CH_APPEND:
               // Bytes arriving now are dropped
               if (!tx_busy)
               begin
                  append_idx <= append_idx + 2'h1;            // [RQ12]
                  if (append_idx == APPEND_LAST)
                     chain_state <= CH_IDLE;
               end
            default:
               chain_state <= CH_IDLE;
         endcase
      end
   end

   // Gateway silence watchdog; a frame's end re-arms it
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         comm_cnt   <= '0;
         comm_fault <= 1'b0;
      end
      else if (chain_state == CH_APPEND)
      begin
         comm_cnt   <= '0;
         comm_fault <= 1'b0;
      end
      else if (comm_cnt == COMM_LIMIT)
         comm_fault <= 1'b1;
      else
         comm_cnt <= comm_cnt + COMM_CNT_W'(1);
   end

   // Cause classes of the fault sense lines
   assign warn_src   = faults.first_output_fault | faults.second_output_fault |
                       faults.cross_short | faults.over_temp;
   assign imm_src    = faults.actuator_fault | faults.actuator_combo | faults.internal_fault;
   assign cause_gone = !warn_src && !imm_src;
   assign env_ok     = guard & actuator & in1 & in2;
   assign error_set  = imm_src || (warn_cnt == WARN_LIMIT);               // [RQ18] [RQ10]
   assign error_clear = cause_gone && (ack_request || (guard_prev && !guard)); // [RQ6]

   // Warning delay; restarts whenever the warning goes away
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         warn_cnt <= '0;
      else if (!warn_src || error_off)
         warn_cnt <= '0;                                               // [RQ11]
      else if (warn_cnt != WARN_LIMIT)
         warn_cnt <= warn_cnt + WARN_CNT_W'(1);                        // [RQ10]
   end

   // Error and lockout latches; a set in the clearing cycle wins
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         error_off  <= 1'b0;
         lockout    <= 1'b0;                                           // [RQ9]
         guard_prev <= 1'b0;
      end
      else
      begin
         guard_prev <= guard;
         if (error_set)
            error_off <= 1'b1;
         else if (error_clear)
            error_off <= 1'b0;
         if ((faults.first_output_fault && faults.second_output_fault) || faults.cross_short)
            lockout <= 1'b1;                                           // [RQ8]
      end
   end

   // Safety outputs; gateway silence plays no part in them
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         out_en               <= 1'b0;
         first_safety_output  <= 1'b0;
         second_safety_output <= 1'b0;
      end
      else
      begin
         out_en               <= env_ok && !error_off && !lockout && !error_set;  // [RQ5]
         first_safety_output  <= env_ok && !error_off && !lockout && !error_set;
         second_safety_output <= env_ok && !error_off && !lockout && !error_set;
      end
   end

   // Error image; output bits clear at re-enable or reload at a new error set
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         error_diag_byte <= error_diag_type'(BYTE_RESET);
      else
      begin
         if (error_clear && !error_set)
         begin
            error_diag_byte.cross_short    <= 1'b0;
            error_diag_byte.over_temp      <= 1'b0;
            error_diag_byte.actuator_fault <= 1'b0;
            error_diag_byte.internal_fault <= 1'b0;
         end
         if (out_en)
         begin
            error_diag_byte.first_output_fault  <= 1'b0;                  // [RQ7]
            error_diag_byte.second_output_fault <= 1'b0;
         end
         if (error_set)
         begin
            error_diag_byte.first_output_fault  <= faults.first_output_fault;   // [RQ16]
            error_diag_byte.second_output_fault <= faults.second_output_fault;
            error_diag_byte.cross_short    <= faults.cross_short;
            error_diag_byte.over_temp      <= faults.over_temp;
            error_diag_byte.actuator_fault <= faults.actuator_fault | faults.actuator_combo;
            error_diag_byte.internal_fault <= faults.internal_fault;
         end
      end
   end

   // Live response and warning images, all bits active high [RQ13]
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_response_byte <= response_type'(BYTE_RESET);
         warning_diag_byte   <= warning_diag_type'(BYTE_RESET);
      end
      else
      begin
         state_response_byte <= '{error_off: error_off | lockout,         // [RQ14]
                                  error_warning: warn_src | comm_fault,
                                  guard_detected: guard,
                                  inputs_active: in1 & in2,
                                  unused3: 1'b0,
                                  unused2: 1'b0,
                                  actuator_detected: actuator,
                                  outputs_enabled: out_en};
         warning_diag_byte   <= '{unused7: 1'b0,                          // [RQ15]
                                  comm_fault: comm_fault,
                                  internal_fault: faults.internal_fault,
                                  unused4: 1'b0,
                                  over_temp: faults.over_temp,
                                  cross_short: faults.cross_short,
                                  second_output_fault: faults.second_output_fault,
                                  first_output_fault: faults.first_output_fault};
      end
   end

endmodule

`default_nettype wire

/* File: verification/diag_gateway_model.sv */
// Purpose: Gateway stand-in on one switch's diagnostic line
// Assumes: Frames of start 0, 8 data bits LSB first, stop 1
// Notes:   Received bytes queue for the bench
`timescale 1ns/1ps
`default_nettype none
module diag_gateway_model
   import safety_diag_pkg::*;
(
   input  wire logic sys_clk,
   output var  logic tx,
   input  wire logic rx
);
   logic [7:0] rx_q[$];

   // Line idles high between frames
   initial tx = 1'b1;

   // One request byte per unit, into the first unit's input
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         tx = f[i];
         repeat (BIT_CYCLES) @(posedge sys_clk);
         #10;
      end
   endtask

   // Mid-bit sampling; one unit, so three bytes per poll
   initial
   begin
      logic [7:0] b;
      forever
      begin
         @(negedge rx);
         repeat (BIT_CYCLES / 2) @(posedge sys_clk);
         for (int i = 0; i < 8; i++)
         begin
            repeat (BIT_CYCLES) @(posedge sys_clk);
            b[i] = rx;
         end
         // Stop not sampled; wait ends at its start, so a back-to-back start is not missed
         repeat (BIT_CYCLES / 2) @(posedge sys_clk);
         rx_q.push_back(b);
      end
   end
endmodule
`default_nettype wire

/* File: verification/safety_diag_checker_sva.sv */
// Purpose: Port checks of enabling, cut-off and framing
// Assumes: Pin filters settle in a few clocks
// Notes:   Run counters allow for pin filtering
`timescale 1ns/1ps
`default_nettype none
module safety_diag_checker
   import safety_diag_pkg::*;
#(
   parameter logic [WARN_CNT_W-1:0] WARN_LIMIT = WARN_CNT_W'(WARN_CYCLES)
)
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic first_safety_input,
   input wire logic second_safety_input,
   input wire logic actuator_present,
   input wire logic guard_closed,
   input wire logic first_output_fault,
   input wire logic second_output_fault,
   input wire logic cross_short,
   input wire logic over_temp,
   input wire logic actuator_fault,
   input wire logic actuator_combo,
   input wire logic internal_fault,
   input wire logic serial_diag_out,
   input wire logic first_safety_output,
   input wire logic second_safety_output
);
   logic                  en_raw;
   logic                  en_ok;
   logic [3:0]            ok_run;
   logic [WARN_CNT_W-1:0] warn_run;
   logic [3:0]            lock_run;
   logic                  locked;

   // Enable terms; over_temp only warns
   assign en_raw = guard_closed & actuator_present & first_safety_input & second_safety_input;
   assign en_ok  = en_raw & !(actuator_fault | actuator_combo | internal_fault | cross_short
                   | first_output_fault | second_output_fault);

   // Runs of clean inputs and held warning
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ok_run   <= 4'h0;
         warn_run <= '0;
      end
      else
      begin
         ok_run   <= en_ok ? ok_run + 4'(ok_run != 4'hf) : 4'h0;
         warn_run <= over_temp ? warn_run + 1'b1 : '0;
      end
   end

   // Lockout cause held 8 cycles; reset forgets
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         lock_run <= 4'h0;
         locked   <= 1'b0;
      end
      else
      begin
         lock_run <= (cross_short | (first_output_fault & second_output_fault))
                     ? lock_run + 4'(lock_run != 4'hf) : 4'h0;
         locked   <= locked | (lock_run == 4'h8);
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   sequence s_hard_fault;
      (actuator_fault || actuator_combo || internal_fault) [*8];
   endsequence
   sequence s_not_enabled;
      (!en_raw) [*8];
   endsequence

   a_hard_fault_cut: assert property (s_hard_fault |=> !first_safety_output)
      else $error("output on under hard fault");
   a_enable_needs_inputs: assert property (s_not_enabled |=> !first_safety_output)
      else $error("output on without enable inputs");
   a_channels_agree: assert property (first_safety_output == second_safety_output)
      else $error("output channels differ");
   a_warning_keeps_on: assert property (first_safety_output && ok_run[3]
      && warn_run < WARN_LIMIT |=> first_safety_output)
      else $error("output dropped in warning delay");
   a_warning_expiry: assert property (warn_run >= WARN_LIMIT + 16 |-> !first_safety_output)
      else $error("output on after warning delay");
   a_lockout_holds: assert property (locked |-> !first_safety_output)
      else $error("output on in lockout");
   a_low_bit_width: assert property ($fell(serial_diag_out) |-> !serial_diag_out [*8])
      else $error("low bit too short");
   a_high_bit_width: assert property ($rose(serial_diag_out) |-> serial_diag_out [*8])
      else $error("high bit too short");
endmodule

bind safety_switch_serial_diagnostics safety_diag_checker
   #(.WARN_LIMIT(WARN_LIMIT)) chk (.sys_clk, .reset_n,
   .first_safety_input, .second_safety_input, .actuator_present, .guard_closed,
   .first_output_fault, .second_output_fault, .cross_short, .over_temp, .actuator_fault,
   .actuator_combo, .internal_fault, .serial_diag_out, .first_safety_output,
   .second_safety_output);
`default_nettype wire

/* File: verification/safety_switch_serial_diagnostics_bench.sv */
// Purpose: Steps the switch through warning, error and lockout
// Assumes: Shortened warning and silence limits
// Notes:   Reset pulses stand in for power cycling
`timescale 1ns/1ps
`default_nettype none
module safety_switch_serial_diagnostics_bench
   import safety_diag_pkg::*;
;
   localparam int WL = 8000;
   localparam int CL = 5000;
   logic sys_clk, reset_n, serial_diag_in, serial_diag_out;
   logic first_safety_input, second_safety_input, actuator_present, guard_closed;
   logic first_output_fault, second_output_fault, cross_short, over_temp;
   logic actuator_fault, actuator_combo, internal_fault;
   logic first_safety_output, second_safety_output;
   int   bad_count = 0;
   int   n_checks = 0;
   int   cycles = 0;

   safety_switch_serial_diagnostics #(.WARN_LIMIT(WARN_CNT_W'(WL)),
      .COMM_LIMIT(COMM_CNT_W'(CL))) uut (.sys_clk, .reset_n, .serial_diag_in,
      .first_safety_input, .second_safety_input, .actuator_present, .guard_closed,
      .first_output_fault, .second_output_fault, .cross_short, .over_temp,
      .actuator_fault, .actuator_combo, .internal_fault, .serial_diag_out,
      .first_safety_output, .second_safety_output);
   diag_gateway_model gw (.sys_clk, .tx(serial_diag_in), .rx(serial_diag_out));

   // 100 ns clock
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   // Hang guard; a run takes about 73k cycles
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 95000)
      begin
         bad_count++;
         final_report();
      end
   end

   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #10;
   endtask

   task automatic check(input string name, input logic [7:0] seen, exp);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Missing bytes read as unknown and fail
   task automatic poll(input logic [7:0] req, resp, warn, err);
      int k = 0;
      gw.rx_q.delete();
      gw.send(req);
      while (gw.rx_q.size() < 3 && k < 9000)
      begin
         step(1);
         k++;
      end
      while (gw.rx_q.size() < 3) gw.rx_q.push_back(8'hxx);
      check("response", gw.rx_q[0], resp);
      check("warning", gw.rx_q[1], warn);
      check("error", gw.rx_q[2], err);
   endtask

   task automatic out_is(input logic v);
      check("safety_out", {7'h00, first_safety_output}, {7'h00, v});
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      reset_n = 1'b0;
      {first_safety_input, second_safety_input, actuator_present, guard_closed} = 4'h0;
      {first_output_fault, second_output_fault, cross_short, over_temp} = 4'h0;
      {actuator_fault, actuator_combo, internal_fault} = 3'h0;
      step(12);
      reset_n = 1'b1;
      {first_safety_input, second_safety_input, actuator_present} = 3'h7;
      step(20);
      poll(8'h00, 8'h12, 8'h00, 8'h00);
      guard_closed = 1'b1;
      step(20);
      out_is(1'b1);
      poll(8'h00, 8'h33, 8'h00, 8'h00);
      // Warning that goes away, then one left to expire
      over_temp = 1'b1;
      step(50);
      out_is(1'b1);
      poll(8'h00, 8'h73, 8'h08, 8'h00);
      over_temp = 1'b0;
      step(20);
      poll(8'h00, 8'h33, 8'h00, 8'h00);
      over_temp = 1'b1;
      step(WL + 20);
      out_is(1'b0);
      poll(8'h00, 8'hf2, 8'h08, 8'h08);
      over_temp = 1'b0;
      poll(8'h80, 8'hb2, 8'h00, 8'h08);
      poll(8'h00, 8'h33, 8'h00, 8'h00);
      // Immediate faults, cleared by opening the guard
      for (int i = 0; i < 3; i++)
      begin
         {internal_fault, actuator_combo, actuator_fault} = 3'h1 << i;
         step(10);
         out_is(1'b0);
         poll(8'h00, 8'hb2, 8'(i / 2 * 32), 8'h10 << i / 2);
         {internal_fault, actuator_combo, actuator_fault} = 3'h0;
         step(10);
         guard_closed = 1'b0;
         step(10);
         guard_closed = 1'b1;
         step(20);
         out_is(1'b1);
      end
      // Silence leaves outputs alone
      step(CL + 1000);
      out_is(1'b1);
      // Lockout by cross short, then by both output faults
      for (int i = 0; i < 2; i++)
      begin
         {first_output_fault, second_output_fault, cross_short} = i ? 3'h6 : 3'h1;
         step(20);
         out_is(1'b0);
         {first_output_fault, second_output_fault, cross_short} = 3'h0;
         guard_closed = 1'b0;
         step(10);
         guard_closed = 1'b1;
         step(20);
         out_is(1'b0);
         reset_n = 1'b0;
         step(2);
         reset_n = 1'b1;
         step(20);
         out_is(1'b1);
      end
      final_report();
   end
endmodule
`default_nettype wire
